/* File: core/fsl_rx.sv */
// Receiver end: parity check, sync monitors, lane release
`default_nettype none
module fsl_rx #(
	parameter int unsigned E_MB      = 1,
	parameter int unsigned ERR_LIM   = 4,
	parameter int unsigned WIN_BLKS  = 64,
	parameter int unsigned RBD_BLKS  = 0
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           reset_n,
	// Link
	fsl_link_if.rx              link,
	// User side
	input  wire logic           all_lanes_ready,
	output logic                syndrome_err,
	output logic [25:0]         syndrome,
	output logic                block_lock,
	output logic                mb_lock,
	output logic                emb_lock,
	output logic                buf_writing,
	output logic                buf_release,
	output logic                sysref_req
);
	typedef struct packed {
		logic [25:0] par;
		logic [25:0] last_par;
		logic        have_last;
		logic [31:0] shs;
		logic [4:0]  blk;
		logic [7:0]  emb;
		logic [15:0] lemc;
		logic [7:0]  win;
		logic [3:0]  hdr_err;
		logic [3:0]  mb_err;
		logic [3:0]  emb_err;
		fsl_pkg::fsl_sync_e st;
		logic [25:0] syn;
		logic        syn_err;
		logic        writing;
		logic        release_p;
		logic        sysref_req;
	} fsl_rx_s;

	fsl_rx_s s_reg, s_next;
	localparam int unsigned LEMC_BLKS = fsl_pkg::BLK_PER_MB * E_MB;

	always_comb
	begin
		logic        bitv;
		logic [31:0] shs;
		logic [25:0] rxp;
		logic        want_eoemb;
		s_next    = s_reg;
		bitv      = 1'b0;
		shs       = 32'h00000000;
		rxp       = 26'h0000000;
		want_eoemb = 1'b0;
		s_next.release_p = 1'b0;
		s_next.lemc = (s_reg.lemc == 16'(LEMC_BLKS - 1)) ? 16'h0000 : s_reg.lemc + 16'h0001;
		if (link.sysref)
			s_next.lemc = 16'h0000; // see R22
		if (link.blk_valid)
		begin
			// Headers are 01 for one, 10 for zero; other patterns are errors
			bitv = (link.hdr == fsl_pkg::HDR_ONE); // see R23
			s_next.par = fsl_pkg::fsl_par_word(s_reg.par, link.payload); // see R3
			shs = s_reg.shs;
			shs[s_reg.blk] = bitv;
			s_next.shs = shs;
			s_next.win = s_reg.win + 8'h01;
			if (s_reg.win == 8'(WIN_BLKS - 1))
			begin
				s_next.win = 8'h00;
				s_next.hdr_err = 4'h0;
				s_next.mb_err = 4'h0;
				s_next.emb_err = 4'h0;
			end
			// Counted after the window clear so an error in its last block is kept
			if (link.hdr != fsl_pkg::HDR_ONE && link.hdr != fsl_pkg::HDR_ZERO)
				s_next.hdr_err = s_next.hdr_err + 4'h1; // see R18
			s_next.blk = s_reg.blk + 5'h01;
			if (s_reg.blk == 5'(fsl_pkg::BLK_PER_MB - 1))
			begin
				rxp = 26'h0000000;
				for (int i = 0; i < 22; i++)
					rxp[25 - i] = shs[i];
				rxp[3] = shs[fsl_pkg::PAR3_POS];
				for (int i = 0; i < 3; i++)
					rxp[2 - i] = shs[fsl_pkg::PAR_LO_POS + i];
				s_next.par = 26'h0000000;
				s_next.last_par = fsl_pkg::fsl_par_word(s_reg.par, link.payload);
				s_next.have_last = 1'b1;
				if (s_reg.have_last)
				begin
					s_next.syn = rxp ^ s_reg.last_par; // see R3, see R5, see R11
					s_next.syn_err = (rxp != s_reg.last_par); // see R3
				end
				// Pilot must sit at the stream end every time
				if (shs[fsl_pkg::PILOT_POS +: 5] != fsl_pkg::PILOT_PAT) // see R8
					s_next.mb_err = s_next.mb_err + 4'h1; // see R19
				want_eoemb = (s_reg.emb == 8'(E_MB - 1));
				if (shs[fsl_pkg::EOEMB_POS] != want_eoemb)
					s_next.emb_err = s_next.emb_err + 4'h1; // see R20
				s_next.emb = want_eoemb ? 8'h00 : s_reg.emb + 8'h01;
				if (want_eoemb && all_lanes_ready && s_reg.st == fsl_pkg::FSL_LOCK)
					s_next.writing = 1'b1; // see R15
			end
		end
		unique case (s_reg.st)
			fsl_pkg::FSL_HUNT:
			begin
				if (s_reg.win == 8'(WIN_BLKS - 1) && s_reg.mb_err == 4'h0 &&
				    s_reg.hdr_err == 4'h0)
					s_next.st = fsl_pkg::FSL_LOCK; // see R14
			end
			fsl_pkg::FSL_LOCK:
			begin
				if (s_reg.hdr_err >= 4'(ERR_LIM) || s_reg.mb_err >= 4'(ERR_LIM) ||
				    s_reg.emb_err >= 4'(ERR_LIM))
				begin
					s_next.st = fsl_pkg::FSL_LOST;
					s_next.writing = 1'b0;
					s_next.sysref_req = 1'b1; // see R21
				end
			end
			fsl_pkg::FSL_LOST:
			begin
				if (link.sysref)
				begin
					s_next.st = fsl_pkg::FSL_HUNT;
					s_next.sysref_req = 1'b0;
					s_next.hdr_err = 4'h0;
					s_next.mb_err = 4'h0;
					s_next.emb_err = 4'h0;
					s_next.win = 8'h00;
				end
			end
		endcase
		// Release at LEMC edge plus programmed delay, kept clear of arrival spread
		if (s_reg.writing && s_reg.lemc == 16'(RBD_BLKS)) // see R16, see R17
			s_next.release_p = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_reg    <= '0;
			s_reg.st <= fsl_pkg::FSL_HUNT;
		end
		else
			s_reg <= s_next;
	end

	// R4: burst correction from syndrome is left to downstream logic
	always_comb syndrome_err = s_reg.syn_err;
	always_comb syndrome     = s_reg.syn;
	always_comb block_lock   = (s_reg.st == fsl_pkg::FSL_LOCK);
	always_comb mb_lock      = (s_reg.st == fsl_pkg::FSL_LOCK);
	always_comb emb_lock     = (s_reg.st == fsl_pkg::FSL_LOCK);
	always_comb buf_writing  = s_reg.writing;
	always_comb buf_release  = s_reg.release_p;
	always_comb sysref_req   = s_reg.sysref_req;
endmodule : fsl_rx
`default_nettype wire

/* File: core/fsl_pkg.sv */
// Shared constants and types for the FEC sync header link ends
`default_nettype none
package fsl_pkg;
	localparam int unsigned BLK_PER_MB    = 32;
	localparam int unsigned PAY_BITS      = 64;
	localparam int unsigned PAR_W         = 26;
	localparam logic [25:0] GEN_POLY      = 26'h0220211;
	localparam int unsigned EOEMB_POS     = 22;
	localparam int unsigned PAR3_POS      = 23;
	localparam int unsigned PAR_LO_POS    = 24;
	localparam int unsigned PILOT_POS     = 27;
	// Bit i lands on stream bit PILOT_POS + i: four zeros, then the closing one
	localparam logic [4:0]  PILOT_PAT     = 5'h10;
	localparam logic [1:0]  HDR_ONE       = 2'h1;
	localparam logic [1:0]  HDR_ZERO      = 2'h2;
	localparam int unsigned LATENCY_BLKS  = 58;
	localparam int unsigned BURST_MAX     = 9;

	// One serial step of the divide by g(x); also used by the receiver
	function automatic logic [25:0] fsl_par_step(input logic [25:0] s, input logic d);
		logic fb;
		fb = s[25] ^ d;
		fsl_par_step = {s[24:0], 1'b0} ^ (fb ? GEN_POLY : 26'h0000000);
	endfunction : fsl_par_step

	// 64 payload bits, first sent bit is bit 0
	function automatic logic [25:0] fsl_par_word(input logic [25:0] s, input logic [63:0] d);
		logic [25:0] t;
		t = s;
		for (int i = 0; i < 64; i++)
			t = fsl_par_step(t, d[i]);
		fsl_par_word = t;
	endfunction : fsl_par_word

	// Sync header stream word from parity and end flag
	function automatic logic [31:0] fsl_shs(input logic [25:0] p, input logic eoemb);
		logic [31:0] w;
		w = 32'h00000000;
		for (int i = 0; i < 22; i++)
			w[i] = p[25 - i];
		w[EOEMB_POS] = eoemb;
		w[PAR3_POS]  = p[3];
		for (int i = 0; i < 3; i++)
			w[PAR_LO_POS + i] = p[2 - i];
		for (int i = 0; i < 5; i++)
			w[PILOT_POS + i] = PILOT_PAT[i];
		fsl_shs = w;
	endfunction : fsl_shs

	typedef enum logic [2:0] {
		FSL_HUNT = 3'h1,
		FSL_LOCK = 3'h2,
		FSL_LOST = 3'h4
	} fsl_sync_e;
endpackage : fsl_pkg
`default_nettype wire

/* File: core/fsl_link_if.sv */
// Block-wide link between transmitter and receiver
`default_nettype none
interface fsl_link_if;
	logic [1:0]  hdr;
	logic [63:0] payload;
	logic        blk_valid;
	logic        sysref;
	modport tx (output hdr, output payload, output blk_valid, input sysref);
	modport rx (input hdr, input payload, input blk_valid, input sysref);
endinterface : fsl_link_if
`default_nettype wire

/* File: core/fsl_tx.sv */
// Transmitter end: Fire-code parity and sync header stream framing
// Overview of operation
// R1: Parity over each 2048-bit scrambled multiblock
// R2: Parity sent in next multiblock's stream
// R3: Receiver syndrome is parity difference
// R4: Nonzero syndrome used to correct error; not done here, the receiver only outputs the syndrome
// R5: Detection latency at least 58 blocks
// R6: Parity bit placement in stream bits
// R7: Stream ends with 00001 pilot
// R8: Receiver finds pilot consistently over multiblocks
// R9: End flag set only on last multiblock
// R10: Generator x26+x21+x17+x9+x4+1
// R11: Shortened 2074,2048 code, 9-bit burst
// R12: Only payload bits feed parity
// R13: Parity register cleared each multiblock
// R14: Receiver locks alignment before lane alignment
// R15: Buffering starts at next extended multiblock
// R16: Release at LEMC edge plus delay
// R17: Release point outside arrival spread
// R18: Every header has transition; errors counted
// R19: Pilot errors in window lose sync
// R20: End flag errors lose extended sync
// R21: Lost sync asks SYSREF reapply
// R22: SYSREF resets LEMC phase
// R23: Header 01 is one, 10 zero
`default_nettype none
module fsl_tx #(
	parameter int unsigned E_MB = 1
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           reset_n,
	// Link
	fsl_link_if.tx              link,
	// User side
	input  wire logic [63:0]    scr_data,
	input  wire logic           data_valid,
	output logic                data_ready,
	output logic [25:0]         last_parity,
	output logic                mb_start
);
	typedef struct packed {
		logic [25:0] par;
		logic [31:0] shs_cur;
		logic [4:0]  blk;
		logic [7:0]  emb;
		logic [1:0]  hdr;
		logic [63:0] payload;
		logic        valid;
		logic [25:0] last_par;
		logic        mb_start;
		logic        rdy;
	} fsl_tx_s;

	fsl_tx_s s_reg, s_next;

	always_comb
	begin
		logic [25:0] p;
		logic        last;
		s_next          = s_reg;
		p               = 26'h0000000;
		last            = 1'b0;
		s_next.valid    = 1'b0;
		s_next.mb_start = 1'b0;
		s_next.rdy      = 1'b1;
		if (link.sysref)
		begin
			// Realign framing to the LEMC edge
			s_next.blk = 5'h00; // see R22
			s_next.emb = 8'h00; // see R22
			// A cut multiblock must not leak into the next parity word
			s_next.par = 26'h0000000; // see R13
			s_next.shs_cur[fsl_pkg::EOEMB_POS] = (E_MB == 1); // see R9
		end
		else if (data_valid)
		begin
			s_next.valid   = 1'b1;
			s_next.payload = scr_data;
			// Header bit from this block's stream position
			s_next.hdr = s_reg.shs_cur[s_reg.blk] ? fsl_pkg::HDR_ONE
				: fsl_pkg::HDR_ZERO; // see R23, see R18
			// Headers never enter the divider
			p = fsl_pkg::fsl_par_word(s_reg.par, scr_data); // see R1, see R10, see R12
			s_next.par = p;
			s_next.blk = s_reg.blk + 5'h01;
			if (s_reg.blk == 5'(fsl_pkg::BLK_PER_MB - 1))
			begin
				last = (s_reg.emb == 8'(E_MB - 1));
				s_next.emb = (s_reg.emb == 8'(E_MB - 1)) ? 8'h00 : s_reg.emb + 8'h01;
				s_next.par = 26'h0000000; // see R13
				s_next.last_par = p;
				s_next.mb_start = 1'b1;
				// Next stream carries this parity, its own end flag and pilot
				s_next.shs_cur = fsl_pkg::fsl_shs(p,
					(E_MB == 1) ? 1'b1 : (s_reg.emb == 8'(E_MB - 2))); // see R2, see R6, see R7, see R9
				if (last && E_MB != 1)
					s_next.shs_cur[fsl_pkg::EOEMB_POS] = 1'b0; // see R9
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_reg     <= '0;
			s_reg.hdr <= fsl_pkg::HDR_ZERO;
			// First stream has zero parity; end flag set when each multiblock ends one
			s_reg.shs_cur <= fsl_pkg::fsl_shs(26'h0000000, E_MB == 1);
		end
		else
			s_reg <= s_next;
	end

	// Full rate path, no stall, so parity lands a fixed 32 blocks late; see R5, see R11
	always_comb data_ready   = s_reg.rdy;
	assign link.hdr         = s_reg.hdr;
	assign link.payload     = s_reg.payload;
	assign link.blk_valid   = s_reg.valid;
	always_comb last_parity = s_reg.last_par;
	always_comb mb_start    = s_reg.mb_start;
endmodule : fsl_tx
`default_nettype wire

/* File: tb/fsl_link_chk.sv */
// Checker for the sync header stream on the link
`default_nettype none
module fsl_link_chk #(
	parameter int unsigned E_MB = 1
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Link
	input wire logic [1:0]  hdr,
	input wire logic [63:0] payload,
	input wire logic        blk_valid,
	input wire logic        sysref
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] ONE = fsl_pkg::HDR_ONE;
	localparam logic [1:0] ZRO = fsl_pkg::HDR_ZERO;
	logic [4:0]  blk_reg;
	int unsigned mb_reg;
	logic [25:0] cur_reg;
	logic [25:0] prev_reg;
	logic        known_reg;

	function automatic logic [25:0] div64(input logic [25:0] s, input logic [63:0] d);
		for (int i = 0; i < 64; i++)
			s = {s[24:0], 1'b0} ^ ((s[25] ^ d[i]) ? fsl_pkg::GEN_POLY : 26'h0);
		return s;
	endfunction : div64

	function automatic logic [1:0] hv(input logic b);
		return b ? ONE : ZRO;
	endfunction : hv

	// Parity unknown after sysref until a whole multiblock is seen
	always_ff @(posedge clk)
		if (!reset_n || sysref)
		begin
			blk_reg   <= 5'h0;
			mb_reg    <= 0;
			cur_reg   <= 26'h0;
			prev_reg  <= 26'h0;
			known_reg <= !reset_n;
		end
		else if (blk_valid)
		begin
			blk_reg <= blk_reg + 5'h1;
			cur_reg <= (blk_reg == 5'h1f) ? 26'h0 : div64(cur_reg, payload);
			if (blk_reg == 5'h1f)
			begin
				prev_reg  <= div64(cur_reg, payload);
				known_reg <= 1'b1;
				mb_reg    <= (mb_reg == E_MB - 1) ? 0 : mb_reg + 1;
			end
		end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_pilot;
		(blk_valid && hdr == ZRO) [*4] ##1 (blk_valid && hdr == ONE);
	endsequence
	property p_hdr;
		blk_valid |-> hdr == ONE || hdr == ZRO;
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("no header transition");
	property p_drop;
		$past(sysref) |-> !blk_valid;
	endproperty
	a_drop: assert property (p_drop)
		else $error("block under sysref");
	property p_par_hi;
		blk_valid && known_reg && blk_reg < 5'h16 |-> hdr == hv(prev_reg[25 - blk_reg]);
	endproperty
	a_par_hi: assert property (p_par_hi)
		else $error("parity bit wrong");
	property p_par3;
		blk_valid && known_reg && blk_reg == 5'h17 |-> hdr == hv(prev_reg[3]);
	endproperty
	a_par3: assert property (p_par3)
		else $error("parity bit 3 wrong");
	property p_par_lo;
		blk_valid && known_reg && blk_reg inside {[5'h18:5'h1a]}
			|-> hdr == hv(prev_reg[26 - blk_reg]);
	endproperty
	a_par_lo: assert property (p_par_lo)
		else $error("low parity wrong");
	property p_end_set;
		blk_valid && blk_reg == 5'h16 && mb_reg == E_MB - 1 |-> hdr == ONE;
	endproperty
	a_end_set: assert property (p_end_set)
		else $error("end flag missing");
	property p_end_clr;
		blk_valid && blk_reg == 5'h16 && mb_reg != E_MB - 1 |-> hdr == ZRO;
	endproperty
	a_end_clr: assert property (p_end_clr)
		else $error("end flag early");
	property p_pilot;
		blk_valid && blk_reg == 5'h1b |-> s_pilot;
	endproperty
	a_pilot: assert property (p_pilot)
		else $error("pilot wrong");
endmodule : fsl_link_chk
`default_nettype wire

/* File: tb/fec_sync_header_lane_align_tb_top.sv */
// Bench: transmitter, receiver, and a receiver on a corruptible copy
`default_nettype none
module fec_sync_header_lane_align_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
		$display("wrong value %0t %h %h", $time, a, b); end end
	localparam logic [63:0] BURST = 64'h1ff;
	logic        clk = 1'b0, reset_n = 1'b0, sysref = 1'b0, dv = 1'b0, rdy = 1'b0;
	logic        hbad = 1'b0, rel = 1'b0;
	logic        serr1, serr2, bl1, bl2, ml1, el1, bw1, br1, sq2, sq1, mbs, drdy;
	logic [63:0] sd = 64'h1, din = 64'h0, flip = 64'h0;
	logic [25:0] lastp, syn1, syn2, cur = 26'h0, done = 26'h0, es;
	int          blk = 0, fb = -1, errors = 0, checked = 0;
	fsl_link_if link ();
	fsl_link_if lk2 ();
	assign link.sysref = sysref;
	assign lk2.sysref = sysref;
	assign lk2.blk_valid = link.blk_valid;
	assign lk2.payload = link.payload ^ flip;
	assign lk2.hdr = hbad ? 2'h3 : link.hdr;
	always #4 clk = ~clk;
	always @(posedge clk)
		if (br1)
			rel <= 1'b1;
	fsl_tx #(.E_MB(2)) u_fsl_tx (.clk(clk), .reset_n(reset_n), .link(link.tx),
		.scr_data(din), .data_valid(dv), .data_ready(drdy), .last_parity(lastp),
		.mb_start(mbs));
	fsl_rx #(.E_MB(2)) u_fsl_rx (.clk(clk), .reset_n(reset_n), .link(link.rx),
		.all_lanes_ready(rdy), .syndrome_err(serr1), .syndrome(syn1), .block_lock(bl1),
		.mb_lock(ml1), .emb_lock(el1), .buf_writing(bw1), .buf_release(br1),
		.sysref_req(sq1));
	// Second receiver sees injected faults only
	fsl_rx #(.E_MB(2)) u_fsl_rx_2 (.clk(clk), .reset_n(reset_n), .link(lk2.rx),
		.all_lanes_ready(rdy), .syndrome_err(serr2), .syndrome(syn2), .block_lock(bl2),
		.mb_lock(), .emb_lock(), .buf_writing(), .buf_release(), .sysref_req(sq2));
	fsl_link_chk #(.E_MB(2)) u_fsl_link_chk (.clk(clk), .reset_n(reset_n), .hdr(link.hdr),
		.payload(link.payload), .blk_valid(link.blk_valid), .sysref(link.sysref));

	function automatic logic [25:0] par64(input logic [25:0] s, input logic [63:0] d);
		for (int i = 0; i < 64; i++)
			s = {s[24:0], 1'b0} ^ ((s[25] ^ d[i]) ? fsl_pkg::GEN_POLY : 26'h0);
		return s;
	endfunction : par64

	task automatic stop_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// Whole multiblocks, back to back; caller drops dv afterwards
	task automatic send_mb(input int n);
		repeat (n * 32)
		begin
			sd = sd * 64'h5851f42d4c957f2d + 64'h1;
			din = sd;
			dv = 1'b1;
			cur = par64(cur, sd);
			@(posedge clk);
			#1;
			flip = (blk == fb) ? BURST : 64'h0;
			fb = (blk == fb) ? -1 : fb;
			`CHK(mbs, (blk == 31))
			if (blk == 2)
				`CHK(lastp, done)
			blk = (blk + 1) % 32;
			if (blk == 0)
			begin
				done = cur;
				cur = 26'h0;
			end
		end
	endtask : send_mb

	task automatic until_set(input int w);
		for (int i = 0; i < 20 && ((w == 0) ? el1 : rel) !== 1'b1; i++)
			send_mb(1);
		if (((w == 0) ? el1 : rel) !== 1'b1)
		begin
			errors++;
			stop_test();
		end
	endtask : until_set

	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		`CHK({link.hdr, link.blk_valid}, {fsl_pkg::HDR_ZERO, 1'b0})
		reset_n = 1'b1;
		@(posedge clk);
		#1;
		sysref = 1'b1;
		dv = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK(link.blk_valid, 1'b0)
		`CHK(drdy, 1'b1)
		sysref = 1'b0;
		until_set(0);
		`CHK({bl1, ml1, serr1, syn1, bw1}, 30'h30000000)
		rdy = 1'b1;
		until_set(1);
		fb = 5;
		send_mb(2);
		dv = 1'b0;
		es = 26'h0;
		for (int k = 5; k < 32; k++)
			es = par64(es, (k == 5) ? BURST : 64'h0);
		repeat (2) @(posedge clk);
		#1;
		`CHK({serr2, syn2}, {1'b1, es})
		`CHK({serr1, syn1}, 27'h0)
		hbad = 1'b1;
		send_mb(1);
		`CHK({bl2, sq2, bl1, sq1}, 4'h6)
		dv = 1'b0;
		hbad = 1'b0;
		sysref = 1'b1;
		@(posedge clk);
		#1;
		sysref = 1'b0;
		`CHK({bl2, sq2}, 2'h0)
		stop_test();
	end
endmodule : fec_sync_header_lane_align_tb_top
`default_nettype wire
